// [asfs_pkg.sv]
/*
 * Package for the serial frame sequencer of the eight-channel converter.
 * Holds cycle counts, bit positions and the packed types shared by the design.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package asfs_pkg;

	// Cycle counts of one conversion, in serial-clock cycles.
	localparam int unsigned TRACK_CYCLES        = 3;
	localparam int unsigned HOLD_CONVERT_CYCLES = 13;
	localparam int unsigned GROUP_CYCLES        = TRACK_CYCLES + HOLD_CONVERT_CYCLES;

	// Falling-edge numbers that frame the result bits, start the hold and end the group.
	localparam logic [4:0] FIRST_RESULT_EDGE = 5'h05;
	localparam logic [4:0] LAST_RESULT_EDGE  = 5'h0C;
	localparam logic [4:0] HOLD_START_EDGE   = 5'h04;
	localparam logic [4:0] LAST_GROUP_EDGE   = 5'h10;

	// Control word layout: channel address sits in bits 5..3 of the 16-bit word.
	localparam int unsigned CTRL_WIDTH = 16;
	localparam int unsigned ADDR_MSB   = 5;
	localparam int unsigned ADDR_LSB   = 3;

	// Reset values.
	localparam logic [2:0] ADDR_RESET   = 3'h0;
	localparam logic [7:0] RESULT_RESET = 8'h00;

	// Buffer depth between the converter core and the shifter.
	localparam int unsigned BUF_DEPTH = 2;

	// One finished conversion: which channel, and its 8-bit code.
	typedef struct packed {
		logic [2:0] chan;
		logic [7:0] code;
	} asfs_sample_t;

	// Synchronised link pins.
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic din;
	} asfs_link_t;

	// Phase of the current 16-edge group.
	typedef enum logic [1:0] {
		ASFS_OFF   = 2'b00,
		ASFS_TRACK = 2'b01,
		ASFS_HOLD  = 2'b10
	} asfs_phase_t;

endpackage

// [asfs_seq.sv]
/*
 * Serial frame sequencer of an eight-channel 8-bit successive-approximation converter.
 * Assumes the link pins come from another clock domain and are slow against clk;
 * the analog core delivers a code for the held channel when asked (conv_req/conv_code).
 */
`timescale 1ns/100ps

// Behaviour
// - Track three cycles, convert thirteen, sixteen total
// - Frame select low runs, high shuts down
// - Output drives after frame select falls
// - Output released after frame select rises
// - Result bits change on falling clock edges
// - Control input sampled on rising clock edges
// - Four zeros, eight bits MSB first, four zeros
// - Retrack at next group's first fall, hold at fourth fall
// - Each conversion loads a new control word
module asfs_seq (
	input  wire logic       clk,       // System clock, 10 MHz.
	input  wire logic       rst_n,     // Asynchronous reset, active low.
	input  wire logic       cs_n_pin,  // Frame select from host, active low.
	input  wire logic       sclk_pin,  // Serial clock from host.
	input  wire logic       din_pin,   // Control input from host.
	input  wire logic [7:0] conv_code, // Code from the analog core for the held channel.
	output logic            dout,      // Serial result output value.
	output logic            dout_oe,   // Result output enable, high while driving.
	output logic            powered,   // High in normal mode, low in shutdown.
	output logic            tracking,  // High while the sampler tracks its input.
	output logic [2:0]      track_chan,// Channel routed to the sampler.
	output logic            conv_req   // Pulse: hold taken, core converts now.
);

	// Two-flop synchronisers; logic reads the second stage and its delayed copy prev.
	asfs_pkg::asfs_link_t sync1;
	asfs_pkg::asfs_link_t sync2;
	asfs_pkg::asfs_link_t prev;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
			sync2 <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
			prev  <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
		end else begin
			sync1 <= '{cs_n: cs_n_pin, sclk: sclk_pin, din: din_pin};
			sync2 <= sync1;
			prev  <= sync2;
		end
	end

	// Edge events; the clock is gated off while frame select is high.
	logic active;
	logic cs_fall;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;

	assign active   = !sync2.cs_n;
	assign cs_fall  = prev.cs_n && !sync2.cs_n;
	assign cs_rise  = !prev.cs_n && sync2.cs_n;
	assign sck_rise = active && !prev.sclk && sync2.sclk;
	assign sck_fall = active && prev.sclk && !sync2.sclk;

	// Sequencer state: falling and rising edge counts within the group.
	asfs_pkg::asfs_phase_t phase;
	asfs_pkg::asfs_phase_t next_phase;
	logic [4:0]            fall_cnt;
	logic [4:0]            next_fall_cnt;
	logic [4:0]            rise_cnt;
	logic [4:0]            next_rise_cnt;
	logic [15:0]           ctrl_shift;
	logic [15:0]           next_ctrl_shift;
	logic [2:0]            chan;
	logic [2:0]            next_chan;
	logic [2:0]            held_chan;
	logic [2:0]            next_held_chan;
	logic                  next_dout;
	logic                  next_dout_oe;
	logic                  next_conv_req;
	logic [7:0]            out_word;
	logic [7:0]            next_out_word;

	// Two-entry buffer between the converter core and the output shifter.
	asfs_pkg::asfs_sample_t buf_mem [asfs_pkg::BUF_DEPTH];
	logic                   wr_ptr;
	logic                   rd_ptr;
	logic [1:0]             count;
	logic                   in_valid;
	logic                   in_ready;
	logic                   out_valid;
	logic                   out_ready;
	logic                   pend;
	logic                   next_pend;

	assign in_ready  = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign in_valid  = pend;
	// Pop on the hold edge itself, so the MSB is ready for the fifth falling edge.
	assign out_ready = sck_fall && (fall_cnt == asfs_pkg::HOLD_START_EDGE - 5'h01);

	// Buffer pointers and storage; a core code waits in pend while full.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
			for (int i = 0; i < asfs_pkg::BUF_DEPTH; i++) begin
				buf_mem[i] <= '0;
			end
		end else begin
			if (in_valid && in_ready) begin
				buf_mem[wr_ptr] <= '{chan: held_chan, code: conv_code};
				wr_ptr          <= !wr_ptr;
			end
			if (out_valid && out_ready) begin
				rd_ptr <= !rd_ptr;
			end
			count <= count + 2'((in_valid && in_ready) ? 1 : 0)
			               - 2'((out_valid && out_ready) ? 1 : 0);
		end
	end

	// Next-state logic for the edge counters, control word and output.
	always_comb begin
		next_phase      = phase;
		next_fall_cnt   = fall_cnt;
		next_rise_cnt   = rise_cnt;
		next_ctrl_shift = ctrl_shift;
		next_chan       = chan;
		next_held_chan  = held_chan;
		next_dout       = dout;
		next_dout_oe    = dout_oe;
		next_conv_req   = 1'b0;
		next_out_word   = out_word;
		next_pend       = pend && !in_ready;
		if (conv_req) begin
			next_pend = 1'b1;
		end
		if (cs_fall) begin
			next_phase    = asfs_pkg::ASFS_TRACK;
			next_fall_cnt = 5'h00;
			next_rise_cnt = 5'h00;
			next_dout_oe  = 1'b1;
			next_dout     = 1'b0;
		end else if (cs_rise) begin
			// Ending on the frame's own signal: no clock edge is awaited.
			next_phase   = asfs_pkg::ASFS_OFF;
			next_dout_oe = 1'b0;
			next_dout    = 1'b0;
		end
		if (sck_rise) begin
			next_ctrl_shift = {ctrl_shift[14:0], sync2.din};
			if (rise_cnt == 5'(asfs_pkg::GROUP_CYCLES - 1)) begin
				next_rise_cnt = 5'h00;
				// Latch the address of the word just completed.
				next_chan = next_ctrl_shift[asfs_pkg::ADDR_MSB:asfs_pkg::ADDR_LSB];
			end else begin
				next_rise_cnt = rise_cnt + 5'h01;
			end
		end
		if (sck_fall) begin
			next_fall_cnt = (fall_cnt == asfs_pkg::LAST_GROUP_EDGE) ? 5'h01
			                                                        : fall_cnt + 5'h01;
			if (next_fall_cnt == asfs_pkg::HOLD_START_EDGE) begin
				next_phase     = asfs_pkg::ASFS_HOLD;
				next_held_chan = chan;
				next_conv_req  = 1'b1;
			end else if (next_fall_cnt == 5'h01) begin
				next_phase = asfs_pkg::ASFS_TRACK;
			end
			// Result bits change only here, after falling edges.
			if (next_fall_cnt >= asfs_pkg::FIRST_RESULT_EDGE
			    && next_fall_cnt <= asfs_pkg::LAST_RESULT_EDGE) begin
				next_dout     = out_word[7];
				next_out_word = {out_word[6:0], 1'b0};
			end else begin
				next_dout = 1'b0;
			end
			if (out_valid && out_ready) begin
				next_out_word = buf_mem[rd_ptr].code;
			end else if (next_fall_cnt == asfs_pkg::HOLD_START_EDGE) begin
				next_out_word = asfs_pkg::RESULT_RESET;
			end
		end
	end

	// Register stage for the sequencer; all outputs come from flops.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase      <= asfs_pkg::ASFS_OFF;
			fall_cnt   <= 5'h00;
			rise_cnt   <= 5'h00;
			ctrl_shift <= '0;
			chan       <= asfs_pkg::ADDR_RESET;
			held_chan  <= asfs_pkg::ADDR_RESET;
			dout       <= 1'b0;
			dout_oe    <= 1'b0;
			conv_req   <= 1'b0;
			out_word   <= asfs_pkg::RESULT_RESET;
			pend       <= 1'b0;
			powered    <= 1'b0;
			tracking   <= 1'b0;
			track_chan <= asfs_pkg::ADDR_RESET;
		end else begin
			phase      <= next_phase;
			fall_cnt   <= next_fall_cnt;
			rise_cnt   <= next_rise_cnt;
			ctrl_shift <= next_ctrl_shift;
			chan       <= next_chan;
			held_chan  <= next_held_chan;
			dout       <= next_dout;
			dout_oe    <= next_dout_oe;
			conv_req   <= next_conv_req;
			out_word   <= next_out_word;
			pend       <= next_pend;
			powered    <= (next_phase != asfs_pkg::ASFS_OFF);
			tracking   <= (next_phase == asfs_pkg::ASFS_TRACK);
			track_chan <= next_chan;
		end
	end

	// Checks kept beside the logic they guard.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_hold_edge;
		sck_fall && (next_fall_cnt == asfs_pkg::HOLD_START_EDGE);
	endsequence

	a_oe_on_fall: assert property (cs_fall |=> dout_oe)
		else $error("Output not enabled after frame start.");
	a_oe_off_rise: assert property (cs_rise |=> !dout_oe && !powered)
		else $error("Output still driven after frame end.");
	a_hold_start: assert property (s_hold_edge |=> conv_req && !tracking)
		else $error("Hold did not start at fourth falling edge.");
	a_dout_stable: assert property (!sck_fall && !cs_fall && !cs_rise |=> $stable(dout))
		else $error("Result output changed off a falling edge.");
	a_lead_zero: assert property (sck_fall && next_fall_cnt < 5'h05 |=> !dout)
		else $error("Leading bit not zero.");
	a_trail_zero: assert property (sck_fall && next_fall_cnt > 5'h0C |=> !dout)
		else $error("Trailing bit not zero.");
	a_retrack: assert property (sck_fall && fall_cnt == 5'h10 |=> tracking)
		else $error("No return to tracking after group end.");
	a_shut_down: assert property (sync2.cs_n && !cs_rise |=> !powered)
		else $error("Powered while frame select high.");
	a_ctrl_sample: assert property (sck_rise |=> ctrl_shift[0] == $past(sync2.din))
		else $error("Control bit not sampled on rising edge.");
	a_addr_load: assert property (sck_rise && rise_cnt == 5'h0F |=> chan == ctrl_shift[5:3])
		else $error("Channel address not loaded.");

endmodule

// [asfs_host.sv]
/* Host model of the serial link: frames, sixteen-edge groups, result capture.
 * Assumes clk at 10 MHz; serial clock half period is four clk cycles. */
`timescale 1ns/100ps
module asfs_host (
	input  wire logic   clk,      // System clock.
	input  wire logic   dout,     // Result bit.
	input  wire logic   dout_oe,  // Result enable.
	input  wire logic   powered,  // Normal mode flag.
	input  wire logic   tracking, // Tracking flag.
	output logic        cs_n,     // Frame select.
	output logic        sclk,     // Serial clock, parked high.
	output logic        din,      // Control input.
	output logic [15:0] rx_word,  // Captured result word.
	output logic [15:0] rx_trk,   // Tracking seen at each rise.
	output logic        rx_on     // Enable and power held over a group.
);
	event rx_done;

	// Idle link: no frame, clock parked, nothing captured yet.
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		din = 1'b0;
		rx_on = 1'b0;
		rx_word = 16'h0000;
		rx_trk = 16'h0000;
	end

	// Open a frame; the clock stays still until the first group.
	task automatic start();
		@(negedge clk);
		cs_n = 1'b0;
		repeat (4) @(negedge clk);
	endtask

	// One group of sixteen rises; din moves on the fall, a half period ahead of the rise.
	task automatic group(input logic [15:0] w);
		rx_on = 1'b1;
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b0;
			din = w[i];
			repeat (4) @(negedge clk);
			sclk = 1'b1;
			rx_word[i] = dout_oe ? dout : ~dout;
			rx_trk[i] = tracking;
			rx_on = rx_on & dout_oe & powered;
			repeat (4) @(negedge clk);
		end
		-> rx_done;
	endtask

	// Close the frame, optionally with the clock low; din no longer holds its value.
	task automatic stop(input bit low);
		if (low) begin
			sclk = 1'b0;
			repeat (4) @(negedge clk);
		end
		cs_n = 1'b1;
		din = ~din;
		repeat (4) @(negedge clk);
		sclk = 1'b1;
	endtask
endmodule

// [asfs_seq_bench.sv]
/* Self-checking bench of the frame sequencer with a host model and a core stub.
 * Assumes the host model file; codes and control words are random. */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module asfs_seq_bench;
	logic        clk, rst_n, cs_n, sclk, din, dout, dout_oe, powered, tracking, conv_req;
	logic        rx_on;
	logic [7:0]  conv_code, prev;
	logic [2:0]  track_chan, ch;
	logic [15:0] rx_word, rx_trk, w;
	logic [7:0]  cq[$];
	logic [2:0]  chq[$];
	int          error_cnt, comparisons;

	// Free-running 10 MHz clock.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	asfs_seq asfs_seq_inst (.clk(clk), .rst_n(rst_n), .cs_n_pin(cs_n), .sclk_pin(sclk),
		.din_pin(din), .conv_code(conv_code), .dout(dout), .dout_oe(dout_oe),
		.powered(powered), .tracking(tracking), .track_chan(track_chan), .conv_req(conv_req));

	asfs_host asfs_host_inst (.clk(clk), .dout(dout), .dout_oe(dout_oe), .powered(powered),
		.tracking(tracking), .cs_n(cs_n), .sclk(sclk), .din(din), .rx_word(rx_word),
		.rx_trk(rx_trk), .rx_on(rx_on));

	task automatic results();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Core stub: a fresh code after each hold; it is noted for the next group's word.
	always @(posedge clk) begin
		if (conv_req === 1'b1) begin
			@(negedge clk);
			conv_code = 8'($urandom);
			cq.push_back(conv_code);
		end
	end

	// Each finished group is judged against the code noted at the previous group's hold and the oldest noted channel.
	always begin
		@(asfs_host_inst.rx_done);
		ch = chq.pop_front();
		`CHK("word", {4'h0, prev, 4'h0}, rx_word)
		`CHK("tracking", 16'hE000, rx_trk)
		`CHK("enabled", 1'b1, rx_on)
		`CHK("channel", ch, track_chan)
		`CHK("conv_req", 1, cq.size())
		prev = cq.pop_front();
	end

	// Frames of one to three groups, the last one closed with the clock low.
	initial begin
		rst_n = 1'b0;
		conv_code = 8'h00;
		prev = asfs_pkg::RESULT_RESET;
		void'($urandom(32'hec5c_928a));
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		for (int f = 0; f < 6; f++) begin
			asfs_host_inst.start();
			for (int g = 0; g <= f % 3; g++) begin
				w = 16'($urandom);
				chq.push_back(w[5:3]);
				asfs_host_inst.group(w);
			end
			asfs_host_inst.stop(f == 5);
			`CHK("oe_after_frame", 1'b0, dout_oe)
			`CHK("power_after_frame", 1'b0, powered)
			`CHK("tracking_after_frame", 1'b0, tracking)
		end
		results();
	end

	// Watchdog: about two and a half times the expected run.
	initial begin
		repeat (4000) @(posedge clk);
		error_cnt++;
		results();
	end
endmodule
